// file: rses_pkg.sv
// Purpose: Shared constants and types for the rename stall event selector.
// Assumes: One core clock; event number and mask are static while counting.
// Notes:   Mask 0FH is the aggregate mask for both event groups.
package rses_pkg;
   // =========================================================================
   // Event numbers and masks
   // =========================================================================
   localparam logic [7:0] EVT_ALIAS     = 8'hD2;  // Alias stage stall group.
   localparam logic [7:0] EVT_SEG       = 8'hD4;  // Segment rename stall group.
   localparam logic [7:0] MSK_ROB_PORT  = 8'h01;  // Reorder read port stall.
   localparam logic [7:0] MSK_PARTIAL   = 8'h02;  // Partial register stall.
   localparam logic [7:0] MSK_FLAGS     = 8'h04;  // Flag stall.
   localparam logic [7:0] MSK_FP_STATUS = 8'h08;  // Status word write.
   localparam logic [7:0] MSK_ANY       = 8'h0F;  // Aggregate.
   localparam logic [7:0] MSK_SEG_ES    = 8'h01;  // ES segment.
   localparam logic [7:0] MSK_SEG_DS    = 8'h02;  // DS segment.
   localparam logic [7:0] MSK_SEG_FS    = 8'h04;  // FS segment.
   localparam logic [7:0] MSK_SEG_GS    = 8'h08;  // GS segment.
   localparam logic [1:0] FP_WRITE_INC  = 2'h2;   // Increment per status write.
   localparam logic [1:0] INC_ONE       = 2'h1;   // Increment per stall cycle.
   localparam logic [1:0] INC_NONE      = 2'h0;   // No increment.
   localparam logic [3:0] FLAGS_ALL     = 4'hF;   // Full set of flag groups.
   localparam logic [3:0] FLAGS_NONE    = 4'h0;   // Empty flag set.

   // =========================================================================
   // Types
   // =========================================================================
   // Programmed selection.
   typedef struct packed {
      logic [7:0] event_num;  // Event number.
      logic [7:0] unit_mask;  // Unit mask.
   } rses_select_t;

   // Per-cycle alias stage conditions.
   typedef struct packed {
      logic       reorder_read_port_stall;  // Read port stall this cycle.
      logic       partial_register_stall;   // Partial register stall.
      logic       other_flag_stall;         // Non-partial flag stall cause.
      logic       fp_status_write_event;    // Status word written.
      logic       flag_write_valid;         // An instruction wrote flags.
      logic [3:0] flag_write_set;           // Flag groups it wrote.
      logic       flag_read_valid;          // A flag reader arrives.
      logic [3:0] flag_read_set;            // Flag groups it reads.
   } rses_alias_t;

   // Per-segment rename view, one bit per ES, DS, FS, GS.
   typedef struct packed {
      logic [3:0] rename;  // Segment renamed this cycle.
      logic [3:0] retire;  // Renamed segment retires this cycle.
      logic [3:0] update;  // Update to segment requested this cycle.
   } rses_seg_t;

   // Decoded selector mode, one-hot.
   typedef enum logic [2:0] {
      SEL_IDLE  = 3'b001,
      SEL_ALIAS = 3'b010,
      SEL_SEG   = 3'b100
   } rses_mode_t;
endpackage

// file: rses_seg_track.sv
// Purpose: Tracks renamed-but-unretired segments and raises front-end stalls.
// Assumes: A retire refers to the single outstanding rename of that segment.
// Notes:   A stalled update must be held by the pipeline until released.
module rses_seg_track (
   input  wire logic               clk_in,      // Core clock.
   input  wire logic               sys_rst_in,  // Synchronous reset, high.
   input  wire rses_pkg::rses_seg_t seg_in,     // Segment rename view.
   output logic [3:0]              stall_out    // Per-segment stall.
);
   // =========================================================================
   // Pending rename tracking
   // =========================================================================
   logic [3:0] pend_r;    // Segment renamed and not yet retired.
   logic [3:0] pend_nxt;  // Next pending set.

   // A retire clears the pending bit; a new rename sets it and wins.
   assign pend_nxt  = (pend_r & ~seg_in.retire) | seg_in.rename;
   // Update to a pending segment stalls until the earlier value retires.
   assign stall_out = pend_r & ~seg_in.retire & seg_in.update;

   // Registers the pending set.
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         pend_r <= 4'h0;
      end else begin
         pend_r <= pend_nxt;
      end
   end

   // A stalled segment stays pending into the next cycle, so a held update is stalled again.
   stall_pend_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      stall_out != 4'h0 |=> (pend_r & $past(stall_out)) == $past(stall_out))
      else $error("Segment pending bit lost while stalled.");
endmodule

// file: rses_top.sv
// Purpose: Selects alias stage and segment rename stall events for counting.
// Assumes: Stall inputs are synchronous one-cycle conditions per core cycle.
// Notes:   Output increment is registered, one cycle after the condition.
module rses_top (
   input  wire logic                  clk_in,       // Core clock, 20 MHz.
   input  wire logic                  sys_rst_in,   // Synchronous reset, high.
   input  wire rses_pkg::rses_select_t sel_in,      // Event number and mask.
   input  wire rses_pkg::rses_alias_t alias_in,     // Alias stage conditions.
   input  wire rses_pkg::rses_seg_t   seg_in,       // Segment rename view.
   output logic [1:0]                 count_inc_out, // Counter increment.
   output logic                       supported_out, // Selection supported.
   output logic [3:0]                 seg_stall_out, // Front-end segment stall.
   output logic                       front_stall_out // Any front-end stall.
);
   // =========================================================================
   // Selection decode
   // =========================================================================
   rses_pkg::rses_mode_t mode_w;        // Decoded event group.
   logic [7:0]           msk_w;         // Selected mask.
   logic                 alias_ok_w;    // Alias mask is supported.
   logic                 seg_ok_w;      // Segment mask is supported.
   logic                 part_flag_w;   // Partial flag stall this cycle.
   logic                 flag_stall_w;  // Any flag stall cause.
   logic                 fp_stall_w;    // Status word write this cycle.
   logic                 alias_any_w;   // Aggregate alias stall.
   logic [3:0]           seg_stall_w;   // Per-segment rename stalls.
   logic [1:0]           alias_inc_w;   // Alias group increment.
   logic [1:0]           seg_inc_w;     // Segment group increment.
   logic [1:0]           inc_nxt;       // Next increment.
   logic [1:0]           inc_r;         // Registered increment.

   // Returns one if the mask is a single supported bit of the low nibble.
   function automatic logic one_hot_nib(input logic [7:0] m);
      one_hot_nib = (m == 8'h01) || (m == 8'h02) || (m == 8'h04) || (m == 8'h08);
   endfunction

   // Returns one increment when the condition holds, else none.
   function automatic logic [1:0] inc_of(input logic c);
      inc_of = c ? rses_pkg::INC_ONE : rses_pkg::INC_NONE;
   endfunction

   assign msk_w      = sel_in.unit_mask;
   assign alias_ok_w = one_hot_nib(msk_w) || (msk_w == rses_pkg::MSK_ANY);
   assign seg_ok_w   = one_hot_nib(msk_w) || (msk_w == rses_pkg::MSK_ANY);

   // Event group decode; any other combination falls to idle.
   always_comb begin
      mode_w = rses_pkg::SEL_IDLE;
      case (sel_in.event_num)
         rses_pkg::EVT_ALIAS: begin
            mode_w = alias_ok_w ? rses_pkg::SEL_ALIAS : rses_pkg::SEL_IDLE;
         end
         rses_pkg::EVT_SEG: begin
            mode_w = seg_ok_w ? rses_pkg::SEL_SEG : rses_pkg::SEL_IDLE;
         end
         default: begin
            mode_w = rses_pkg::SEL_IDLE;
         end
      endcase
   end

   // =========================================================================
   // Alias stage conditions
   // =========================================================================
   // Writer updated a strict subset; reader needs a flag the writer left alone.
   assign part_flag_w = alias_in.flag_write_valid && alias_in.flag_read_valid &&
                        (alias_in.flag_write_set != rses_pkg::FLAGS_ALL) &&
                        (alias_in.flag_write_set != rses_pkg::FLAGS_NONE) &&
                        ((alias_in.flag_read_set & ~alias_in.flag_write_set) != rses_pkg::FLAGS_NONE);
   assign flag_stall_w = part_flag_w || alias_in.other_flag_stall;
   assign fp_stall_w   = alias_in.fp_status_write_event;
   assign alias_any_w  = alias_in.reorder_read_port_stall || alias_in.partial_register_stall ||
                         flag_stall_w || fp_stall_w;

   // Alias group increment by mask.
   always_comb begin
      alias_inc_w = rses_pkg::INC_NONE;
      case (msk_w)
         rses_pkg::MSK_ROB_PORT: begin
            alias_inc_w = inc_of(alias_in.reorder_read_port_stall);
         end
         rses_pkg::MSK_PARTIAL: begin
            alias_inc_w = inc_of(alias_in.partial_register_stall);
         end
         rses_pkg::MSK_FLAGS: begin
            alias_inc_w = inc_of(flag_stall_w);
         end
         rses_pkg::MSK_FP_STATUS: begin
            alias_inc_w = fp_stall_w ? rses_pkg::FP_WRITE_INC : rses_pkg::INC_NONE;
         end
         rses_pkg::MSK_ANY: begin
            alias_inc_w = inc_of(alias_any_w);
         end
         default: begin
            alias_inc_w = rses_pkg::INC_NONE;
         end
      endcase
   end

   // =========================================================================
   // Segment rename stalls
   // =========================================================================
   // Tracks pending renames and produces per-segment stalls.
   rses_seg_track u_track (
      .clk_in     (clk_in),
      .sys_rst_in (sys_rst_in),
      .seg_in     (seg_in),
      .stall_out  (seg_stall_w)
   );

   // Segment group increment by mask.
   always_comb begin
      seg_inc_w = rses_pkg::INC_NONE;
      case (msk_w)
         rses_pkg::MSK_SEG_ES: begin
            seg_inc_w = inc_of(seg_stall_w[0]);
         end
         rses_pkg::MSK_SEG_DS: begin
            seg_inc_w = inc_of(seg_stall_w[1]);
         end
         rses_pkg::MSK_SEG_FS: begin
            seg_inc_w = inc_of(seg_stall_w[2]);
         end
         rses_pkg::MSK_SEG_GS: begin
            seg_inc_w = inc_of(seg_stall_w[3]);
         end
         rses_pkg::MSK_ANY: begin
            seg_inc_w = inc_of(seg_stall_w != 4'h0);
         end
         default: begin
            seg_inc_w = rses_pkg::INC_NONE;
         end
      endcase
   end

   // =========================================================================
   // Output selection and registers
   // =========================================================================
   assign inc_nxt = (mode_w == rses_pkg::SEL_ALIAS) ? alias_inc_w :
                    (mode_w == rses_pkg::SEL_SEG)   ? seg_inc_w : rses_pkg::INC_NONE;
   assign supported_out   = (mode_w != rses_pkg::SEL_IDLE);
   assign seg_stall_out   = seg_stall_w;
   assign front_stall_out = (seg_stall_w != 4'h0);
   assign count_inc_out   = inc_r;

   // Registers the increment; it follows the condition by one cycle.
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         inc_r <= rses_pkg::INC_NONE;
      end else begin
         inc_r <= inc_nxt;
      end
   end

   // =========================================================================
   // Assertions
   // =========================================================================
   // Partial register selection counts exactly the stall cycles it saw.
   partial_reg_inc_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (sel_in.event_num == rses_pkg::EVT_ALIAS && sel_in.unit_mask == rses_pkg::MSK_PARTIAL) |->
      ##1 (count_inc_out ==
           ($past(alias_in.partial_register_stall) ? rses_pkg::INC_ONE : rses_pkg::INC_NONE)))
      else $error("Partial register increment wrong.");
   // A flag stall from another cause is counted under the flag mask.
   flag_stall_inc_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (sel_in.event_num == rses_pkg::EVT_ALIAS && sel_in.unit_mask == rses_pkg::MSK_FLAGS &&
       alias_in.other_flag_stall) |-> ##1 count_inc_out == rses_pkg::INC_ONE)
      else $error("Flag stall not counted.");
   // A write of every flag group can never leave a partial flag stall.
   full_flag_write_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (alias_in.flag_write_set == rses_pkg::FLAGS_ALL) |-> !part_flag_w)
      else $error("Partial flag stall on full flag write.");
   // Each status word write advances the count by two.
   fp_write_two_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (sel_in.event_num == rses_pkg::EVT_ALIAS && sel_in.unit_mask == rses_pkg::MSK_FP_STATUS &&
       alias_in.fp_status_write_event) |-> ##1 count_inc_out == rses_pkg::FP_WRITE_INC)
      else $error("Status word write not counted by two.");
   // The aggregate alias mask includes read port stalls.
   alias_any_inc_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (sel_in.event_num == rses_pkg::EVT_ALIAS && sel_in.unit_mask == rses_pkg::MSK_ANY &&
       alias_in.reorder_read_port_stall) |-> ##1 count_inc_out == rses_pkg::INC_ONE)
      else $error("Aggregate alias stall not counted.");
   // The FS mask follows the FS stall alone.
   seg_one_inc_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (sel_in.event_num == rses_pkg::EVT_SEG && sel_in.unit_mask == rses_pkg::MSK_SEG_FS) |->
      ##1 (count_inc_out == ($past(seg_stall_out[2]) ? rses_pkg::INC_ONE : rses_pkg::INC_NONE)))
      else $error("FS rename stall increment wrong.");
   // The aggregate segment mask counts any segment stall.
   seg_any_inc_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (sel_in.event_num == rses_pkg::EVT_SEG && sel_in.unit_mask == rses_pkg::MSK_ANY &&
       front_stall_out) |-> ##1 count_inc_out == rses_pkg::INC_ONE)
      else $error("Aggregate segment stall not counted.");
   // An update two cycles after an unretired ES rename is stalled.
   seg_hold_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (seg_in.rename[0] ##1 !seg_in.retire[0] ##1 (seg_in.update[0] && !seg_in.retire[0])) |->
      seg_stall_out[0])
      else $error("Update to unretired ES not stalled.");
   // A read port stall that repeats is counted on every retry cycle.
   rob_retry_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (sel_in.event_num == rses_pkg::EVT_ALIAS && sel_in.unit_mask == rses_pkg::MSK_ROB_PORT &&
       alias_in.reorder_read_port_stall)[*2] |-> ##1 count_inc_out == rses_pkg::INC_ONE)
      else $error("Read port retry stall not counted again.");
   // An unsupported selection never produces an increment.
   unsupported_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      !supported_out |=> count_inc_out == rses_pkg::INC_NONE)
      else $error("Increment on unsupported selection.");

   // Main scenarios that the bench is expected to reach.
   fp_write_c: cover property (@(posedge clk_in) disable iff (sys_rst_in)
      count_inc_out == rses_pkg::FP_WRITE_INC);
   seg_stall_c: cover property (@(posedge clk_in) disable iff (sys_rst_in)
      front_stall_out && mode_w == rses_pkg::SEL_SEG);
   part_flag_c: cover property (@(posedge clk_in) disable iff (sys_rst_in) part_flag_w);
   seg_release_c: cover property (@(posedge clk_in) disable iff (sys_rst_in)
      seg_stall_out[0] ##1 !seg_stall_out[0]);
   unsupported_c: cover property (@(posedge clk_in) disable iff (sys_rst_in) !supported_out);
endmodule

// file: rses_pipe_model.sv
// Purpose: Pipeline and counter model on the far side of the stall selector.
// Assumes: The bench raises update requests as one-cycle pulses.
// Notes:   A stalled update stays presented until the stall drops.
module rses_pipe_model (
   input  wire logic        clk_in,      // Core clock.
   input  wire logic        sys_rst_in,  // Synchronous reset, high.
   input  wire logic [1:0]  inc_in,      // Counter increment.
   input  wire logic [3:0]  stall_in,    // Per-segment front-end stall.
   input  wire logic [3:0]  upd_req_in,  // New segment update requests.
   output logic      [3:0]  upd_out,     // Updates shown to the selector.
   output logic      [15:0] total_out    // Accumulated event count.
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================================================
   // Counter and update holding
   // ==========================================================================
   // The counter adds each increment; a held update is retried while stalled.
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         upd_out   <= 4'h0;
         total_out <= 16'h0000;
      end else begin
         upd_out   <= upd_req_in | (upd_out & stall_in);
         total_out <= total_out + {14'h0000, inc_in};
      end
   end
endmodule

// file: test_rses_top.sv
// Purpose: Self-checking bench for the rename stall event selector.
// Assumes: Inputs change 5 ns after each rising edge.
// Notes:   Event totals are read from the counter model.
module test_rses_top;
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================================================
   // Signals
   // ==========================================================================
   logic                   clk_in     = 1'b0;    // Core clock, 50 ns period.
   logic                   sys_rst_in = 1'b1;    // Synchronous reset.
   rses_pkg::rses_select_t sel        = '0;      // Event selection.
   rses_pkg::rses_alias_t  al         = '0;      // Alias stage conditions.
   logic [3:0]             ren        = 4'h0;    // Rename pulses.
   logic [3:0]             ret        = 4'h0;    // Retire pulses.
   logic [3:0]             upd_req    = 4'h0;    // Update requests.
   logic [3:0]             upd;                  // Held updates.
   logic [1:0]             count_inc;            // Increment output.
   logic                   supported;            // Selection supported.
   logic [3:0]             seg_stall;            // Segment stalls.
   logic                   front_stall;          // Any front-end stall.
   logic [15:0]            total;                // Model counter.
   int                     mismatches = 0;       // Mismatch count.
   int                     n_checks   = 0;       // Comparison count.
   int                     cyc        = 0;       // Cycle count for timeout.
   rses_pkg::rses_seg_t    seg;                  // Segment view.
   assign seg = '{rename: ren, retire: ret, update: upd};
   // ==========================================================================
   // Instances and clock
   // ==========================================================================
   rses_top u_rses_top (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .sel_in(sel), .alias_in(al),
      .seg_in(seg), .count_inc_out(count_inc), .supported_out(supported),
      .seg_stall_out(seg_stall), .front_stall_out(front_stall));
   rses_pipe_model u_rses_pipe_model (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .inc_in(count_inc), .stall_in(seg_stall), .upd_req_in(upd_req), .upd_out(upd),
      .total_out(total));
   // The clock toggles every half period.
   always #25 clk_in = ~clk_in;
   // A hung run is cut short after a fixed number of cycles.
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 4000) begin
         mismatches++;
         wrap_up();
      end
   end
   // ==========================================================================
   // Shared tasks
   // ==========================================================================
   // Advances one edge and lets its updates settle.
   task automatic step();
      @(posedge clk_in);
      #5;
   endtask
   // Compares a seen value with the expected one.
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Prints the verdict and ends the run.
   task automatic wrap_up();
      if (mismatches == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Builds an alias stage condition word.
   function automatic rses_pkg::rses_alias_t mk(input logic r, p, o, f, wv, input logic [3:0] ws,
                                                input logic rv, input logic [3:0] rs);
      mk = '{r, p, o, f, wv, ws, rv, rs};
   endfunction
   // ==========================================================================
   // Scenarios
   // ==========================================================================
   // Holds conditions for n cycles and compares the counted total.
   task automatic run_alias(input logic [7:0] ev, m, input rses_pkg::rses_alias_t a,
                            input int n, input logic [15:0] exp, input logic sup);
      logic [15:0] base;
      sel = '{event_num: ev, unit_mask: m};
      step();
      step();
      base = total;
      chk({15'h0000, supported}, {15'h0000, sup});
      al = a;
      repeat (n) step();
      al = '0;
      step();
      step();
      chk(total - base, exp);
   endtask
   // Renames one segment, stalls a second update one cycle, then retires it.
   task automatic seg_case(input int i, input logic [7:0] m, input logic [15:0] exp);
      logic [15:0] base;
      sel = '{event_num: 8'hD4, unit_mask: m};
      upd_req = 4'h1 << i;
      step();
      upd_req = 4'h0;
      step();
      chk({12'h000, seg_stall}, 16'h0000);
      base = total;
      ren = 4'h1 << i;
      step();
      ren = 4'h0;
      upd_req = 4'h1 << i;
      step();
      upd_req = 4'h0;
      chk({12'h000, seg_stall}, 16'h1 << i);
      chk({15'h0000, front_stall}, 16'h0001);
      step();
      chk({12'h000, seg_stall}, 16'h1 << i);
      ret = 4'h1 << i;
      #1;
      chk({12'h000, seg_stall}, 16'h0000);
      step();
      ret = 4'h0;
      step();
      step();
      chk(total - base, exp);
   endtask
   // Clears a pending rename and the increment with a mid-run reset.
   task automatic reset_case();
      sel = '{event_num: 8'hD2, unit_mask: 8'h08};
      al = mk(0, 0, 0, 1, 0, 4'h0, 0, 4'h0);
      ren = 4'h1;
      step();
      ren = 4'h0;
      sys_rst_in = 1'b1;
      step();
      step();
      chk({14'h0000, count_inc}, 16'h0000);
      sys_rst_in = 1'b0;
      al = '0;
      upd_req = 4'h1;
      step();
      upd_req = 4'h0;
      chk({12'h000, seg_stall}, 16'h0000);
   endtask
   // ==========================================================================
   // Main sequence
   // ==========================================================================
   initial begin
      repeat (2) step();
      sys_rst_in = 1'b0;
      run_alias(8'hD2, 8'h01, mk(1, 0, 0, 0, 0, 4'h0, 0, 4'h0), 3, 16'h0003, 1);
      run_alias(8'hD2, 8'h02, mk(0, 1, 0, 0, 0, 4'h0, 0, 4'h0), 4, 16'h0004, 1);
      run_alias(8'hD2, 8'h02, mk(1, 0, 1, 1, 0, 4'h0, 0, 4'h0), 3, 16'h0000, 1);
      run_alias(8'hD2, 8'h04, mk(0, 0, 1, 0, 0, 4'h0, 0, 4'h0), 2, 16'h0002, 1);
      run_alias(8'hD2, 8'h04, mk(0, 0, 0, 0, 1, 4'h3, 1, 4'h4), 3, 16'h0003, 1);
      run_alias(8'hD2, 8'h04, mk(0, 0, 0, 0, 1, 4'hF, 1, 4'h4), 3, 16'h0000, 1);
      run_alias(8'hD2, 8'h04, mk(0, 0, 0, 0, 1, 4'h3, 1, 4'h1), 3, 16'h0000, 1);
      run_alias(8'hD2, 8'h08, mk(0, 0, 0, 1, 0, 4'h0, 0, 4'h0), 3, 16'h0006, 1);
      run_alias(8'hD2, 8'h0F, mk(1, 1, 1, 0, 0, 4'h0, 0, 4'h0), 3, 16'h0003, 1);
      run_alias(8'hD2, 8'h0F, mk(0, 1, 0, 0, 0, 4'h0, 0, 4'h0), 2, 16'h0002, 1);
      run_alias(8'hD2, 8'h03, mk(1, 1, 1, 1, 0, 4'h0, 0, 4'h0), 3, 16'h0000, 0);
      run_alias(8'hD3, 8'h01, mk(1, 0, 0, 0, 0, 4'h0, 0, 4'h0), 3, 16'h0000, 0);
      run_alias(8'hD4, 8'h01, mk(1, 1, 1, 1, 0, 4'h0, 0, 4'h0), 3, 16'h0000, 1);
      for (int i = 0; i < 4; i++) begin
         seg_case(i, 8'h01 << i, 16'h0001);
         seg_case(i, 8'h01 << ((i + 1) % 4), 16'h0000);
         seg_case(i, 8'h0F, 16'h0001);
      end
      reset_case();
      wrap_up();
   end
endmodule
